// [rtl/aso_defines.vh]
// constants for the converter sync and cmos output interface block
`ifndef ASO_DEFINES_VH
`define ASO_DEFINES_VH
// register addresses
`define ASO_ADDR_FMT_A      8'h8f
`define ASO_ADDR_FMT_B      8'h92
`define ASO_ADDR_SYNC       8'h10
`define ASO_ADDR_IFACE      8'h11
`define ASO_ADDR_DECIM      8'h12
`define ASO_ADDR_STATUS     8'h13
// reset values
`define ASO_FMT_RST         8'h00
`define ASO_IFACE_RST       8'h00
`define ASO_DECIM_RST       8'h00
// field positions
`define ASO_FMT_OFFBIN      0
`define ASO_SYNC_PIN_SEL    0
`define ASO_SYNC_TRIG       1
`define ASO_SYNC_MIX_RST    2
`define ASO_IF_SERIAL       0
`define ASO_IF_DDR          1
`define ASO_IF_ONE_LANE     2
`define ASO_IF_SE_CLK       3
`define ASO_IF_RES_LO       4
`define ASO_IF_RES_HI       5
`define ASO_DC_EN           0
`define ASO_DC_CPLX         1
`define ASO_DC_LOG_LO       2
`define ASO_DC_LOG_HI       4
// resolution codes
`define ASO_RES_14          2'd0
`define ASO_RES_16          2'd1
`define ASO_RES_18          2'd2
`define ASO_RES_20          2'd3
`define ASO_MSB_FLIP        20'h8_0000
`define ASO_SAMPLE_W        14
`define ASO_OUT_W           20
`define ASO_DIV_W           6
`define ASO_SHIFT_W         5
`endif

// [rtl/aso_sync_cmos_out.v]
// sync handling, number format and cmos output interface of the converter back end
`timescale 1ns/1ps
`default_nettype none
`include "aso_defines.vh"

// What this block does
// - sample sync pin on rising sampling clock
// - config bit selects powerdown or sync pin
// - sync from register or pin, decimation only
// - sync resets dividers, aligns I and Q
// - dividers free-run without sync
// - sync restarts oscillator, loads new frequency
// - complex only DDR, real always SDR
// - complex parallel clock Fs/N, data 2Fs/N
// - real parallel clock Fs/M, one word per clock even with DDR set
// - serial complex frame Fs/N, halved two lanes, lane 2R/L/N
// - serial real lane R/L/M, frame halved two lanes
// - serial mode uses two lanes or one
// - 16-bit: eight or sixteen bits per lane
// - parallel clock made inside, chosen by registers
// - serial default launches on both clock edges
// - single-edge mode: double input clock, rising only
// - single-edge mode halves input clock internally
// - twos complement default, offset binary selectable
// - offset binary flips the sign bit
// - extend samples to 14, 16, 18 or 20 bits
module aso_sync_cmos_out (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // register write and read port
  input  wire        reg_wr,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // shared powerdown or sync pin
  input  wire        powerdown_or_align_pin,
  output reg         power_down,
  // samples from the filter path
  input  wire        sample_valid,
  input  wire [13:0] sample_i,
  input  wire [13:0] sample_q,
  // receiver supplied serial clock, sampled as a level
  input  wire        serial_input_clock,
  // strobes to the decimation filter and oscillator
  output reg         divider_reset,
  output reg         osc_restart,
  // cmos output pins
  output reg         output_data_clock,
  output reg         frame_clock,
  output reg  [19:0] data_out
);

  // reset release through two flip-flops
  reg        rst_meta;
  reg        rst_sync_n;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  reg  [7:0] fmt_a;
  reg  [7:0] fmt_b;
  reg  [7:0] sync_ctl;
  reg  [7:0] iface;
  reg  [7:0] decim;
  reg        sync_trig;
  reg        mix_trig;

  // register writes; trigger bits self-clear
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fmt_a     <= `ASO_FMT_RST;
      fmt_b     <= `ASO_FMT_RST;
      sync_ctl  <= `ASO_FMT_RST;
      iface     <= `ASO_IFACE_RST;
      decim     <= `ASO_DECIM_RST;
      sync_trig <= 1'b0;
      mix_trig  <= 1'b0;
    end else begin
      sync_trig <= 1'b0;
      mix_trig  <= 1'b0;
      if (reg_wr) begin
        if (reg_addr == `ASO_ADDR_FMT_A) begin
          fmt_a <= reg_wdata;
        end else if (reg_addr == `ASO_ADDR_FMT_B) begin
          fmt_b <= reg_wdata;
        end else if (reg_addr == `ASO_ADDR_SYNC) begin
          sync_ctl  <= reg_wdata;
          sync_trig <= reg_wdata[`ASO_SYNC_TRIG];
          mix_trig  <= reg_wdata[`ASO_SYNC_MIX_RST];
        end else if (reg_addr == `ASO_ADDR_IFACE) begin
          iface <= reg_wdata;
        end else if (reg_addr == `ASO_ADDR_DECIM) begin
          decim <= reg_wdata;
        end
      end
    end
  end

  wire       pin_sync   = sync_ctl[`ASO_SYNC_PIN_SEL];
  wire       offbin     = fmt_a[`ASO_FMT_OFFBIN] & fmt_b[`ASO_FMT_OFFBIN];
  wire       serial     = iface[`ASO_IF_SERIAL];
  wire       one_lane   = iface[`ASO_IF_ONE_LANE];
  wire       se_clk     = iface[`ASO_IF_SE_CLK];
  wire [1:0] res        = iface[`ASO_IF_RES_HI:`ASO_IF_RES_LO];
  wire       dec_en     = decim[`ASO_DC_EN];
  wire       cplx       = decim[`ASO_DC_CPLX] & dec_en;
  wire [2:0] dec_log    = decim[`ASO_DC_LOG_HI:`ASO_DC_LOG_LO];
  // complex output forces DDR in parallel mode
  wire       ddr        = iface[`ASO_IF_DDR] | cplx;

  // pin latch and edge detect
  reg        pin_q;
  reg        pin_q2;
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_q  <= 1'b0;
      pin_q2 <= 1'b0;
    end else begin
      pin_q  <= powerdown_or_align_pin & pin_sync;
      pin_q2 <= pin_q;
    end
  end
  wire pin_rise  = pin_q & ~pin_q2;
  wire sync_evt  = dec_en & (pin_rise | sync_trig);

  // powerdown use of the shared pin
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      power_down <= 1'b0;
    end else begin
      power_down <= powerdown_or_align_pin & ~pin_sync;
    end
  end

  // reset strobes to the divider and oscillator
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      divider_reset <= 1'b0;
      osc_restart   <= 1'b0;
    end else begin
      divider_reset <= sync_evt;
      osc_restart   <= sync_evt | mix_trig;
    end
  end

  // decimation divider, free running unless synced
  reg  [`ASO_DIV_W-1:0] div_cnt;
  wire [`ASO_DIV_W-1:0] div_mask = (dec_en) ?
    ((6'h01 << dec_log) - 6'h01) : 6'h00;
  wire div_wrap = ((div_cnt & div_mask) == div_mask);
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_cnt <= {`ASO_DIV_W{1'b0}};
    end else if (sync_evt) begin
      div_cnt <= {`ASO_DIV_W{1'b0}};
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  // format and widen a sample
  function [19:0] fmt_sample;
    input [13:0] s;
    input [1:0]  r;
    input        ob;
    reg   [19:0] w;
    begin
      w = {s, 6'h00};
      if (ob) begin
        w = w ^ `ASO_MSB_FLIP;
      end
      case (r)
        `ASO_RES_14: fmt_sample = {6'h00, w[19:6]};
        `ASO_RES_16: fmt_sample = {4'h0, w[19:4]};
        `ASO_RES_18: fmt_sample = {2'h0, w[19:2]};
        default:     fmt_sample = w;
      endcase
    end
  endfunction

  // align I and Q of one output sample
  reg [19:0] word_i;
  reg [19:0] word_q;
  reg        word_new;
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      word_i   <= 20'h0_0000;
      word_q   <= 20'h0_0000;
      word_new <= 1'b0;
    end else begin
      word_new <= sample_valid & div_wrap;
      if (sample_valid & div_wrap) begin
        word_i <= fmt_sample(sample_i, res, offbin);
        word_q <= fmt_sample(sample_q, res, offbin);
      end
    end
  end

  // serial bits per lane per frame, from resolution and lanes
  wire [`ASO_SHIFT_W-1:0] res_bits = 5'd14 + {2'b00, res, 1'b0};
  wire [`ASO_SHIFT_W-1:0] lane_bits = one_lane ? res_bits :
    {1'b0, res_bits[4:1]};
  // leading pad bits of a right-justified word; shifting them off sends the msb first
  wire [`ASO_SHIFT_W-1:0] pad_bits = 5'd20 - res_bits;

  // single-edge mode halves the receiver clock
  reg sic_q;
  reg half_tgl;
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sic_q    <= 1'b0;
      half_tgl <= 1'b0;
    end else begin
      sic_q <= serial_input_clock;
      if (serial_input_clock & ~sic_q) begin
        half_tgl <= ~half_tgl;
      end
    end
  end
  wire sic_rise = serial_input_clock & ~sic_q;
  wire sic_edge = serial_input_clock ^ sic_q;
  // one bit per input edge by default, per falling edge of halved clock otherwise
  wire bit_step = se_clk ? (sic_rise & half_tgl) : sic_edge;

  // output pin process
  reg [`ASO_SHIFT_W:0]   bit_cnt; // one bit wider: a complex frame holds two samples
  reg [39:0]             sh_i;    // i then q back to back for the single lane
  reg [19:0]             sh_q;
  reg                    q_phase;
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      output_data_clock <= 1'b0;
      frame_clock       <= 1'b0;
      data_out          <= 20'h0_0000;
      bit_cnt           <= 6'd0;
      sh_i              <= 40'h00_0000_0000;
      sh_q              <= 20'h0_0000;
      q_phase           <= 1'b0;
    end else if (!serial) begin
      // parallel: clock generated here from the divider
      if (word_new) begin
        output_data_clock <= 1'b1;
        data_out          <= word_i;
        q_phase           <= cplx;
      end else if (ddr & q_phase) begin
        output_data_clock <= 1'b0;
        data_out          <= word_q;
        q_phase           <= 1'b0;
      end else begin
        output_data_clock <= 1'b0;
      end
      frame_clock <= word_new;
    end else begin
      // serial: clock follows receiver clock
      output_data_clock <= se_clk ? half_tgl : serial_input_clock;
      if (word_new & (bit_cnt == 6'd0)) begin
        sh_i        <= ({word_i, 20'h0_0000} |
                        ({20'h0_0000, word_q} << pad_bits)) << pad_bits;
        sh_q        <= word_q << pad_bits;
        bit_cnt     <= cplx ? {lane_bits, 1'b0} : {1'b0, lane_bits};
        frame_clock <= ~frame_clock | one_lane;
      end else if (bit_step & (bit_cnt != 6'd0)) begin
        data_out[0] <= sh_i[39];
        data_out[1] <= one_lane ? 1'b0 : sh_q[19];
        sh_i        <= {sh_i[38:0], 1'b0};
        sh_q        <= {sh_q[18:0], 1'b0};
        bit_cnt     <= bit_cnt - 6'd1;
        if (one_lane) begin
          frame_clock <= 1'b0;
        end
      end
    end
  end

  // read back
  always @* begin
    if (reg_addr == `ASO_ADDR_FMT_A) begin
      reg_rdata = fmt_a;
    end else if (reg_addr == `ASO_ADDR_FMT_B) begin
      reg_rdata = fmt_b;
    end else if (reg_addr == `ASO_ADDR_SYNC) begin
      reg_rdata = {7'h00, sync_ctl[`ASO_SYNC_PIN_SEL]};
    end else if (reg_addr == `ASO_ADDR_IFACE) begin
      reg_rdata = iface;
    end else if (reg_addr == `ASO_ADDR_DECIM) begin
      reg_rdata = decim;
    end else if (reg_addr == `ASO_ADDR_STATUS) begin
      reg_rdata = {2'b00, div_cnt};
    end else begin
      reg_rdata = 8'h00;
    end
  end

endmodule // aso_sync_cmos_out
`default_nettype wire

// [tb/aso_capture_model.sv]
// capture device model: makes the serial input clock and watches lane 0
`timescale 1ns/1ps
`default_nettype none
module aso_capture_model (
  // clock and control
  input  wire logic        ref_clk,
  input  wire logic        run,
  input  wire logic        clr,
  // link signals
  output var  logic        serial_input_clock,
  input  wire logic        lane0,
  output var  logic [15:0] lane_moves
);
  logic ph;
  logic last;
  initial begin
    serial_input_clock = 1'b0;
    ph = 1'b0;
    last = 1'b0;
    lane_moves = 16'h0000;
  end
  // receiver clock runs only while run is high and idles low whenever run is low
  always @(posedge ref_clk) begin
    ph <= run ? ~ph : 1'b0;
    serial_input_clock <= run ? serial_input_clock ^ ph : 1'b0;
    last <= lane0;
    lane_moves <= clr ? 16'h0000 : lane_moves + {15'h0000, lane0 != last};
  end
endmodule // aso_capture_model
`default_nettype wire

// [tb/aso_sync_cmos_out_assertions.sv]
// assertion checker for the sync and cmos output block
`timescale 1ns/1ps
`default_nettype none
`include "aso_defines.vh"
module aso_sync_cmos_out_chk (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // register port
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // pin and strobes
  input wire logic       powerdown_or_align_pin,
  input wire logic       power_down,
  input wire logic       divider_reset,
  input wire logic       osc_restart
);
  reg  pin_sel;
  reg  dec_en;
  wire wr_sync = reg_wr && reg_addr == `ASO_ADDR_SYNC;
  // shadow copies of the pin function and decimation enable
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sel <= 1'b0;
      dec_en  <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `ASO_ADDR_SYNC) pin_sel <= reg_wdata[0];
      if (reg_addr == `ASO_ADDR_DECIM) dec_en <= reg_wdata[0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  one_pulse_a: assert property (
    divider_reset |=> !divider_reset) else $error("divider reset held too long");
  osc_with_div_a: assert property (
    divider_reset |-> osc_restart) else $error("sync without oscillator restart");
  trig_sync_a: assert property (
    wr_sync && reg_wdata[1] && dec_en |-> ##2 divider_reset) else $error("sync write lost");
  no_decim_a: assert property (
    wr_sync && reg_wdata[1] && !dec_en && !pin_sel |-> ##2 !divider_reset)
    else $error("sync acted without decimation");
  mix_rst_a: assert property (
    wr_sync && reg_wdata[2] && dec_en |-> ##[1:3] osc_restart) else $error("mixer restart lost");
  pin_sync_a: assert property (
    pin_sel && dec_en && $rose(powerdown_or_align_pin) |-> ##[2:4] divider_reset)
    else $error("pin sync lost");
  pd_block_a: assert property (
    pin_sel && $past(pin_sel) |-> !power_down) else $error("power down while pin is sync");
  fmt_keep_a: assert property (
    reg_wr && reg_addr == `ASO_ADDR_FMT_A ##1 !reg_wr && reg_addr == `ASO_ADDR_FMT_A
    |-> reg_rdata == $past(reg_wdata)) else $error("format register not kept");
endmodule // aso_sync_cmos_out_chk
bind aso_sync_cmos_out aso_sync_cmos_out_chk chk (.ref_clk, .rst_n, .reg_wr, .reg_addr,
  .reg_wdata, .reg_rdata, .powerdown_or_align_pin, .power_down, .divider_reset, .osc_restart);
`default_nettype wire

// [tb/tb_aso_sync_cmos_out.sv]
// self-checking bench for the sync and cmos output block
`timescale 1ns/1ps
`default_nettype none
`include "aso_defines.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_aso_sync_cmos_out;
  reg         ref_clk = 0, rst_n = 0, reg_wr = 0, sample_valid = 0, run = 0, clr = 0, p = 0;
  reg         powerdown_or_align_pin = 0;
  reg  [7:0]  reg_addr = 0, reg_wdata = 0;
  reg  [13:0] sample_i = 0, sample_q = 0;
  wire [7:0]  reg_rdata;
  wire [19:0] data_out;
  wire [15:0] moves;
  wire        power_down, divider_reset, osc_restart, output_data_clock, frame_clock;
  wire        serial_input_clock;
  int         n_fail = 0, cmp_count = 0, k;
  aso_sync_cmos_out uut (.ref_clk, .rst_n, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .powerdown_or_align_pin, .power_down, .sample_valid, .sample_i, .sample_q,
    .serial_input_clock, .divider_reset, .osc_restart, .output_data_clock, .frame_clock,
    .data_out);
  aso_capture_model cap (.ref_clk, .run, .clr, .serial_input_clock, .lane0(data_out[0]),
    .lane_moves(moves));
  initial forever #12.5 ref_clk = ~ref_clk;
  task step(input int n); repeat (n) @(posedge ref_clk); #2; endtask
  task wr(input [7:0] a, input [7:0] d);
    // idle cycle after each write so the strobe never drops and rises in one time step
    reg_addr = a; reg_wdata = d; reg_wr = 1; step(1); reg_wr = 0; step(1);
  endtask
  task rd(input [7:0] a, input [7:0] e);
    reg_addr = a; #1; `CHK(reg_rdata, e)
  endtask
  // wait for a word on the parallel pins and compare it
  task word(input [19:0] e);
    k = 0; step(2);
    while (output_data_clock !== 1'b1 && k < 40) begin step(1); k++; end
    `CHK({output_data_clock, frame_clock}, 2'b11)
    `CHK(data_out, e)
  endtask
  // count rising edges of the output data clock over n cycles
  task rises(input int n, input int e);
    k = 0; p = output_data_clock;
    repeat (n) begin step(1); k += (output_data_clock === 1'b1 && !p); p = output_data_clock; end
    `CHK(k, e)
  endtask
  task fmt(input [7:0] a, input [7:0] b, input [13:0] s, input [19:0] e);
    wr(`ASO_ADDR_FMT_A, a); wr(`ASO_ADDR_FMT_B, b);
    sample_i = s; sample_valid = 1; step(4); word(e);
  endtask
  task finish_test;
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(25 * 5000); n_fail++; finish_test;
  end
  initial begin
    step(10); rst_n = 1; step(3);
    rd(`ASO_ADDR_FMT_A, `ASO_FMT_RST);
    rd(`ASO_ADDR_FMT_B, `ASO_FMT_RST);
    rd(`ASO_ADDR_IFACE, `ASO_IFACE_RST);
    rd(8'h00, 8'h00);
    wr(`ASO_ADDR_FMT_A, 8'h01); rd(`ASO_ADDR_FMT_A, 8'h01);
    fmt(8'h00, 8'h00, 14'h1fff, 20'h0_1fff);
    fmt(8'h00, 8'h00, 14'h2000, 20'h0_2000);
    fmt(8'h01, 8'h00, 14'h2000, 20'h0_2000);
    fmt(8'h01, 8'h01, 14'h1fff, 20'h0_3fff);
    fmt(8'h01, 8'h01, 14'h0000, 20'h0_2000);
    wr(`ASO_ADDR_IFACE, 8'h20); fmt(8'h01, 8'h01, 14'h2000, 20'h0_0000);
    // real decimation by four, sdr: one clock rise per four samples
    wr(`ASO_ADDR_IFACE, 8'h00); wr(`ASO_ADDR_DECIM, 8'h09); step(8);
    rises(64, 16);
    // complex ddr: i word then q word
    wr(`ASO_ADDR_FMT_A, 8'h00); wr(`ASO_ADDR_IFACE, 8'h02); wr(`ASO_ADDR_DECIM, 8'h0b);
    sample_i = 14'h0123; sample_q = 14'h0456;
    word(20'h0_0123);
    step(1); `CHK(data_out, 20'h0_0456)
    // register sync, divider phase after 64 clocks, mixer restart, sync with decimation off
    wr(`ASO_ADDR_SYNC, 8'h02); `CHK(divider_reset, 1'b1)
    `CHK(osc_restart, 1'b1)
    step(1); `CHK(divider_reset, 1'b0)
    rd(`ASO_ADDR_STATUS, 8'h01); step(63);
    rd(`ASO_ADDR_STATUS, 8'h00);
    wr(`ASO_ADDR_SYNC, 8'h04); `CHK(osc_restart, 1'b1)
    `CHK(divider_reset, 1'b0)
    step(3);
    wr(`ASO_ADDR_DECIM, 8'h00); wr(`ASO_ADDR_SYNC, 8'h02); `CHK(divider_reset, 1'b0)
    step(3);
    // pin sync: one pulse per rising pin edge
    wr(`ASO_ADDR_DECIM, 8'h0b); wr(`ASO_ADDR_SYNC, 8'h01); step(2);
    powerdown_or_align_pin = 1; k = 0;
    repeat (10) begin step(1); k += (divider_reset === 1'b1); end
    `CHK(k, 1)
    powerdown_or_align_pin = 0; wr(`ASO_ADDR_SYNC, 8'h00); step(2);
    powerdown_or_align_pin = 1; step(4); `CHK(power_down, 1'b1)
    powerdown_or_align_pin = 0; step(4); `CHK(power_down, 1'b0)
    // serial one lane at sixteen bits, receiver clock on then stopped
    wr(`ASO_ADDR_IFACE, 8'h15); sample_i = 14'h1555; sample_valid = 1;
    clr = 1; run = 1; step(1); clr = 0; step(200);
    `CHK(moves != 16'h0000, 1'b1)
    rises(64, 16);
    wr(`ASO_ADDR_IFACE, 8'h1d); rises(64, 8);
    run = 0; sample_valid = 0; step(20); clr = 1; step(1); clr = 0; step(40);
    `CHK(moves, 16'h0000)
    finish_test;
  end
endmodule // tb_aso_sync_cmos_out
`default_nettype wire
